/* File: core/cad_datapath.sv */
// Core arithmetic datapath: ALU, flags, multiplier, divider, shifter, control registers
`timescale 1ns/1ns
`default_nettype none

module cad_datapath
  import cad_pkg::*;
(
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  input  wire logic [3:0]       pstrb,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Execution request from the decoder
  input  wire logic             op_valid,
  input  wire cad_pkg::cad_op_t op_code,
  input  wire logic             op_byte,
  input  wire logic [15:0]      op_a,
  input  wire logic [15:0]      op_b,
  input  wire logic [15:0]      op_hi,
  input  wire logic             op_wide,
  input  wire logic             op_signed,
  input  wire cad_pkg::cad_mul_t mul_form,
  input  wire logic             op_abort,
  input  wire logic             loop_active,
  input  wire logic [15:0]      data_addr,
  // Results
  output logic      [31:0]      result,
  output logic                  result_valid,
  output logic      [15:0]      quotient_reg,
  output logic      [15:0]      remainder_reg,
  output logic                  div_done,
  output logic                  div_busy,
  output logic      [15:0]      alu_status_reg,
  output logic      [15:0]      cpu_control_reg,
  output logic                  user_int_disable,
  output logic                  program_window_hit,
  output logic      [22:0]      program_window_addr
);

  ////////////////////////////////////////////////////////////////////////////////
  cad_state_s_t q, d;

  logic        wr_acc;
  logic        rd_acc;
  logic [16:0] sum17;
  logic [15:0] res16;
  logic        cin;
  logic        sub;
  logic        msb;
  logic        c_out;
  logic        dc_out;
  logic        ov_out;
  logic        is_zero;
  logic [15:0] b_eff;
  logic [4:0]  nib;
  logic [8:0]  low9;
  logic [3:0]  sh_amt;
  logic [16:0] ma;
  logic [16:0] mb;
  logic [33:0] mprod;
  logic [31:0] dividend;
  logic [31:0] num_mag;
  logic [15:0] den_mag;
  logic [16:0] trial;
  logic [15:0] mq;
  logic [16:0] mr;
  logic        flags_upd;

  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;

  ////////////////////////////////////////////////////////////////////////////////
  // Adder, shared by add and subtract forms
  always_comb begin
    sub   = (op_code == CAD_OP_SUB) || (op_code == CAD_OP_SBB);
    b_eff = sub ? ~op_b : op_b;
    unique case (op_code)
      CAD_OP_ADD: cin = 1'b0;
      CAD_OP_SUB: cin = 1'b1;
      CAD_OP_ADC,
      CAD_OP_SBB: cin = q.status[CAD_C_BIT];
      default:    cin = 1'b0;
    endcase
    if (op_byte) begin
      sum17 = {8'h00, {1'b0, op_a[7:0]} + {1'b0, b_eff[7:0]} + {8'h00, cin}};
    end else begin
      sum17 = {1'b0, op_a} + {1'b0, b_eff} + {16'h0000, cin};
    end
    nib  = {1'b0, op_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
    low9 = {1'b0, op_a[7:0]} + {1'b0, b_eff[7:0]} + {8'h00, cin};
  end

  // Shifter: amount masked to 0..15 for word, 0..7 for byte
  assign sh_amt = op_byte ? {1'b0, op_b[2:0]} : op_b[3:0];

  always_comb begin
    res16  = 16'h0000;
    c_out  = q.status[CAD_C_BIT];
    dc_out = q.status[CAD_DC_BIT];
    ov_out = q.status[CAD_OV_BIT];
    flags_upd = 1'b0;
    unique case (op_code)
      CAD_OP_ADD, CAD_OP_ADC, CAD_OP_SUB, CAD_OP_SBB: begin
        // Byte carry sits in bit 8 of the sum; keep it out of the result
        res16  = op_byte ? {8'h00, sum17[7:0]} : sum17[15:0];
        flags_upd = 1'b1;
        c_out  = op_byte ? sum17[8] : sum17[16];
        dc_out = op_byte ? nib[4] : low9[8];
        if (op_byte) begin
          ov_out = (op_a[7] == b_eff[7]) && (sum17[7] != op_a[7]);
        end else begin
          ov_out = (op_a[15] == b_eff[15]) && (sum17[15] != op_a[15]);
        end
      end
      CAD_OP_AND: begin res16 = op_a & op_b; flags_upd = 1'b1; end
      CAD_OP_OR:  begin res16 = op_a | op_b; flags_upd = 1'b1; end
      CAD_OP_XOR: begin res16 = op_a ^ op_b; flags_upd = 1'b1; end
      CAD_OP_ASR: begin
        flags_upd = 1'b1;
        if (op_byte) begin
          res16 = {8'h00, 8'($signed(op_a[7:0]) >>> sh_amt)};
        end else begin
          res16 = 16'($signed(op_a) >>> sh_amt);
        end
      end
      CAD_OP_SHL: begin
        flags_upd = 1'b1;
        res16 = op_byte ? {8'h00, 8'(op_a[7:0] << sh_amt)} : 16'(op_a << sh_amt);
      end
      CAD_OP_LSR: begin
        flags_upd = 1'b1;
        res16 = op_byte ? {8'h00, 8'(op_a[7:0] >> sh_amt)} : 16'(op_a >> sh_amt);
      end
      default: res16 = 16'h0000;
    endcase
    msb     = op_byte ? res16[7] : res16[15];
    is_zero = op_byte ? (res16[7:0] == 8'h00) : (res16 == 16'h0000);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Multiplier: 17x17 with per-operand sign extension chosen by form
  always_comb begin
    unique case (mul_form)
      CAD_MUL_SS: begin ma = {op_a[15], op_a}; mb = {op_b[15], op_b}; end
      CAD_MUL_UU: begin ma = {1'b0, op_a};     mb = {1'b0, op_b};     end
      CAD_MUL_SL: begin ma = {op_a[15], op_a}; mb = {12'h000, op_b[4:0]}; end
      CAD_MUL_UL: begin ma = {1'b0, op_a};     mb = {12'h000, op_b[4:0]}; end
      CAD_MUL_US: begin ma = {1'b0, op_a};     mb = {op_b[15], op_b}; end
      CAD_MUL_U8: begin ma = {9'h000, op_a[7:0]}; mb = {9'h000, op_b[7:0]}; end
      default:    begin ma = {1'b0, op_a};     mb = {1'b0, op_b};     end
    endcase
    mprod = 34'($signed(ma) * $signed(mb));
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Divider operands: odd register of the pair is the upper half
  always_comb begin
    dividend = op_wide ? {op_hi, op_a} : (op_signed ? {{16{op_a[15]}}, op_a} : {16'h0000, op_a});
    num_mag  = (op_signed && dividend[31]) ? 32'(-dividend) : dividend;
    den_mag  = (op_signed && op_b[15]) ? 16'(-op_b) : op_b;
    // One non-restoring step: add or subtract divisor by remainder sign
    trial = q.rem[16] ? 17'({q.rem[15:0], q.quo[15]} + {1'b0, q.divisor})
                      : 17'({q.rem[15:0], q.quo[15]} - {1'b0, q.divisor});
    // Final remainder fixup after the last step
    mr = q.rem[16] ? 17'(q.rem + {1'b0, q.divisor}) : q.rem;
    mq = q.quo;
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    d.res_valid = 1'b0;
    d.div_done  = 1'b0;
    d.pready    = 1'b0;
    d.pslverr   = 1'b0;
    d.status[CAD_RA_BIT] = loop_active;

    unique case (q.st)
      CAD_ST_IDLE: begin
        if (op_valid && op_code == CAD_OP_MUL) begin
          d.result    = mprod[31:0];
          d.res_valid = 1'b1;
        end else if (op_valid && op_code == CAD_OP_DIV) begin
          d.st         = CAD_ST_DIV;
          d.rem        = 17'h00000;
          d.quo        = num_mag[15:0];
          d.divisor    = den_mag;
          d.div_signed = op_signed;
          d.num_neg    = op_signed && dividend[31];
          d.den_neg    = op_signed && op_b[15];
          d.cnt        = 5'd1;
          if (op_wide) begin
            d.rem = {1'b0, num_mag[31:16]};
          end
        end else if (op_valid && op_code != CAD_OP_NOP) begin
          d.result    = {16'h0000, res16};
          d.res_valid = 1'b1;
          if (flags_upd) begin
            d.status[CAD_N_BIT]  = msb;
            d.status[CAD_C_BIT]  = c_out;
            d.status[CAD_DC_BIT] = dc_out;
            d.status[CAD_OV_BIT] = ov_out;
            if (!is_zero) begin
              d.status[CAD_Z_BIT] = 1'b0;
            end
          end
        end
      end
      CAD_ST_DIV: begin
        d.cnt = 5'(q.cnt + 5'd1);
        if (op_abort) begin
          d.st = CAD_ST_IDLE;
        end else if (q.cnt <= 5'd16) begin
          d.rem = trial;
          d.quo = {q.quo[14:0], ~trial[16]};
        end else if (q.cnt == 5'd17) begin
          d.rem = mr;
        end else if (q.cnt == 5'd18) begin
          d.quo = (q.num_neg ^ q.den_neg) ? 16'(-mq) : mq;
          d.rem = q.num_neg ? 17'(-q.rem) : q.rem;
        end
        if (!op_abort && q.cnt == CAD_DIV_CYCLES - 5'd1) begin
          d.st       = CAD_ST_IDLE;
          d.div_done = 1'b1;
        end
      end
      default: d.st = CAD_ST_IDLE;
    endcase

    // APB register writes and reads
    if (wr_acc && !q.pready) begin
      d.pready = 1'b1;
      unique case (paddr)
        CAD_STATUS_OFS: begin
          if (pstrb[1]) d.status[CAD_DC_BIT] = pwdata[CAD_DC_BIT];
          if (pstrb[0]) begin
            d.status[CAD_N_BIT]  = pwdata[CAD_N_BIT];
            d.status[CAD_OV_BIT] = pwdata[CAD_OV_BIT];
            d.status[CAD_C_BIT]  = pwdata[CAD_C_BIT];
            d.status[CAD_Z_BIT]  = pwdata[CAD_Z_BIT];
            if (!q.nest_dis) begin
              d.status[CAD_PL_LSB +: 3] = pwdata[CAD_PL_LSB +: 3];
            end
          end
        end
        CAD_CONTROL_OFS: if (pstrb[0]) begin
          d.control[CAD_PWE_BIT] = pwdata[CAD_PWE_BIT];
          if (!pwdata[CAD_PA7_BIT]) d.control[CAD_PA7_BIT] = 1'b0;
        end
        CAD_PAGE_OFS:   if (pstrb[0]) d.page = pwdata[7:0];
        CAD_INTCTL_OFS: if (pstrb[1]) d.nest_dis = pwdata[CAD_NSD_BIT];
        default: d.pslverr = 1'b1;
      endcase
    end else if (rd_acc && !q.pready) begin
      d.pready = 1'b1;
      unique case (paddr)
        CAD_STATUS_OFS:  d.prdata = {16'h0000, q.status};
        CAD_CONTROL_OFS: d.prdata = {16'h0000, q.control};
        CAD_PAGE_OFS:    d.prdata = {24'h000000, q.page};
        CAD_INTCTL_OFS:  d.prdata = {16'h0000, q.nest_dis, 15'h0000};
        default: begin
          d.prdata  = 32'h00000000;
          d.pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q         <= '0;
      q.st      <= CAD_ST_IDLE;
      q.status  <= CAD_STATUS_RST;
      q.control <= CAD_CONTROL_RST;
      q.page    <= CAD_PAGE_RST;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, all registered
  logic        pwin_hit_q;
  logic [22:0] pwin_addr_q;
  logic        uid_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwin_hit_q  <= 1'b0;
      pwin_addr_q <= 23'h000000;
      uid_q       <= 1'b0;
    end else begin
      pwin_hit_q  <= q.control[CAD_PWE_BIT] && data_addr[15];
      pwin_addr_q <= {q.page, data_addr[14:0]};
      uid_q       <= q.control[CAD_PA7_BIT] || (q.status[7:5] == 3'b111);
    end
  end

  assign prdata              = q.prdata;
  assign pready              = q.pready;
  assign pslverr             = q.pslverr;
  assign result              = q.result;
  assign result_valid        = q.res_valid;
  assign quotient_reg        = q.quo;
  assign remainder_reg       = q.rem[15:0];
  assign div_done            = q.div_done;
  assign div_busy            = q.st[1];
  assign alu_status_reg      = q.status;
  assign cpu_control_reg     = q.control;
  assign user_int_disable    = uid_q;
  assign program_window_hit  = pwin_hit_q;
  assign program_window_addr = pwin_addr_q;

endmodule : cad_datapath

`default_nettype wire

/* File: core/cad_pkg.sv */
// Package: constants and types of the core arithmetic datapath
package cad_pkg;

  // Register map (APB byte addresses)
  localparam logic [7:0] CAD_STATUS_OFS   = 8'h00;
  localparam logic [7:0] CAD_CONTROL_OFS  = 8'h04;
  localparam logic [7:0] CAD_PAGE_OFS     = 8'h08;
  localparam logic [7:0] CAD_INTCTL_OFS   = 8'h0c;

  // Status register fields
  localparam int CAD_C_BIT   = 0;
  localparam int CAD_Z_BIT   = 1;
  localparam int CAD_OV_BIT  = 2;
  localparam int CAD_N_BIT   = 3;
  localparam int CAD_RA_BIT  = 4;
  localparam int CAD_PL_LSB  = 5;
  localparam int CAD_DC_BIT  = 8;
  // Control register fields
  localparam int CAD_PA7_BIT = 3;
  localparam int CAD_PWE_BIT = 2;
  // Interrupt control one field
  localparam int CAD_NSD_BIT = 15;

  localparam logic [15:0] CAD_STATUS_RST  = 16'h0000;
  localparam logic [15:0] CAD_CONTROL_RST = 16'h0000;
  localparam logic [7:0]  CAD_PAGE_RST    = 8'h00;

  // Divide timing: one cycle per divisor bit plus setup and fixup cycles
  localparam logic [4:0] CAD_DIV_CYCLES = 5'd19;

  // Operation codes from the instruction decoder
  typedef enum logic [3:0] {
    CAD_OP_ADD  = 4'h0,
    CAD_OP_ADC  = 4'h1,
    CAD_OP_SUB  = 4'h2,
    CAD_OP_SBB  = 4'h3,
    CAD_OP_AND  = 4'h4,
    CAD_OP_OR   = 4'h5,
    CAD_OP_XOR  = 4'h6,
    CAD_OP_ASR  = 4'h7,
    CAD_OP_SHL  = 4'h8,
    CAD_OP_LSR  = 4'h9,
    CAD_OP_MUL  = 4'ha,
    CAD_OP_DIV  = 4'hb,
    CAD_OP_NOP  = 4'hf
  } cad_op_t;

  // Multiply forms
  typedef enum logic [2:0] {
    CAD_MUL_SS  = 3'd0,
    CAD_MUL_UU  = 3'd1,
    CAD_MUL_SL  = 3'd2,
    CAD_MUL_UL  = 3'd3,
    CAD_MUL_US  = 3'd4,
    CAD_MUL_U8  = 3'd5
  } cad_mul_t;

  typedef enum logic [1:0] {
    CAD_ST_IDLE = 2'b01,
    CAD_ST_DIV  = 2'b10
  } cad_state_t;

  typedef struct packed {
    cad_state_t  st;
    logic [15:0] status;
    logic [15:0] control;
    logic [7:0]  page;
    logic        nest_dis;
    logic [31:0] result;
    logic        res_valid;
    logic [16:0] rem;
    logic [15:0] quo;
    logic [15:0] divisor;
    logic        div_signed;
    logic        num_neg;
    logic        den_neg;
    logic [4:0]  cnt;
    logic        div_done;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } cad_state_s_t;

endpackage : cad_pkg

/* File: verif/cad_datapath_monitor.sv */
// Port-level checker of the core arithmetic datapath
`timescale 1ns/1ns
`default_nettype none

module cad_datapath_monitor
  import cad_pkg::*;
(
  // Clock and reset
  input wire logic             pclk,
  input wire logic             presetn,
  // APB
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pready,
  input wire logic             pslverr,
  // Operation request
  input wire logic             op_valid,
  input wire cad_pkg::cad_op_t op_code,
  input wire logic             op_byte,
  input wire logic [15:0]      op_a,
  input wire logic [15:0]      op_b,
  input wire logic             op_abort,
  input wire logic             loop_active,
  input wire logic [15:0]      data_addr,
  // Results and registers
  input wire logic             result_valid,
  input wire logic             div_done,
  input wire logic             div_busy,
  input wire logic [15:0]      alu_status_reg,
  input wire logic [15:0]      cpu_control_reg,
  input wire logic             user_int_disable,
  input wire logic             program_window_hit,
  input wire logic [22:0]      program_window_addr
);
  logic [4:0]  cnt_q;
  logic [4:0]  cnt_d;
  logic        take;
  logic [16:0] add_w;

  assign take  = op_valid && !div_busy;
  assign add_w = {1'b0, op_a} + {1'b0, op_b};

  // Cycles since a divide was taken; an abort forgets it
  always_comb begin
    cnt_d = 5'd0;
    if (take && op_code == CAD_OP_DIV) begin
      cnt_d = 5'd1;
    end else if (cnt_q != 5'd0 && !op_abort && cnt_q != 5'd18) begin
      cnt_d = cnt_q + 5'd1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 5'd0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////
  property p_apb_wait;
    psel && penable && !pready |=> pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("pready late");
  property p_apb_pulse;
    pready |=> !pready;
  endproperty
  a_apb_pulse: assert property (p_apb_pulse) else $error("pready not a pulse");
  property p_apb_err;
    pslverr |-> pready;
  endproperty
  a_apb_err: assert property (p_apb_err) else $error("pslverr without pready");
  property p_one_cycle;
    take && op_code != CAD_OP_DIV && op_code != CAD_OP_NOP |=> result_valid;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("result late");
  property p_refuse;
    op_valid && div_busy |=> !result_valid;
  endproperty
  a_refuse: assert property (p_refuse) else $error("op taken while busy");
  property p_div_time;
    cnt_q == 5'd18 && !op_abort |=> div_done;
  endproperty
  a_div_time: assert property (p_div_time) else $error("divide not done in 19");
  property p_div_busy;
    cnt_q != 5'd0 |-> div_busy && !div_done;
  endproperty
  a_div_busy: assert property (p_div_busy) else $error("divide not busy");
  property p_abort;
    cnt_q != 5'd0 && op_abort |=> !div_done ##1 (!div_busy && !div_done);
  endproperty
  a_abort: assert property (p_abort) else $error("abort ignored");
  property p_carry;
    take && op_code == CAD_OP_ADD && !op_byte
      |=> alu_status_reg[CAD_C_BIT] == $past(add_w[16]);
  endproperty
  a_carry: assert property (p_carry) else $error("carry wrong");
  property p_zero_keep;
    take && op_code == CAD_OP_ADD && !op_byte && add_w[15:0] == 16'h0000
      |=> $stable(alu_status_reg[CAD_Z_BIT]);
  endproperty
  a_zero_keep: assert property (p_zero_keep) else $error("zero not sticky");
  property p_loop;
    alu_status_reg[CAD_RA_BIT] == $past(loop_active);
  endproperty
  a_loop: assert property (p_loop) else $error("loop flag wrong");
  property p_uid;
    cpu_control_reg[CAD_PA7_BIT] || (&alu_status_reg[7:5]) |-> ##[0:1] user_int_disable;
  endproperty
  a_uid: assert property (p_uid) else $error("interrupts not disabled");
  property p_window;
    cpu_control_reg[CAD_PWE_BIT] && data_addr[15]
      |=> program_window_hit && program_window_addr[14:0] == $past(data_addr[14:0]);
  endproperty
  a_window: assert property (p_window) else $error("window map wrong");
  property p_no_window;
    !cpu_control_reg[CAD_PWE_BIT] |=> !program_window_hit;
  endproperty
  a_no_window: assert property (p_no_window) else $error("window while off");
endmodule : cad_datapath_monitor

bind cad_datapath cad_datapath_monitor u_mon (.pclk, .presetn, .psel, .penable, .pready,
  .pslverr, .op_valid, .op_code, .op_byte, .op_a, .op_b, .op_abort, .loop_active,
  .data_addr, .result_valid, .div_done, .div_busy, .alu_status_reg, .cpu_control_reg,
  .user_int_disable, .program_window_hit, .program_window_addr);

`default_nettype wire

/* File: verif/test_cad_datapath.sv */
// Self-checking bench of the core arithmetic datapath
`timescale 1ns/1ns
`default_nettype none

module test_cad_datapath;
  import cad_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic op_valid, op_byte, op_wide, op_signed, op_abort, loop_active;
  logic result_valid, div_done, div_busy, user_int_disable, program_window_hit;
  logic [7:0]  paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata, result, rd;
  logic [15:0] op_a, op_b, op_hi, data_addr, quotient_reg, remainder_reg;
  logic [15:0] alu_status_reg, cpu_control_reg;
  logic [22:0] program_window_addr;
  cad_op_t     op_code;
  cad_mul_t    mul_form;
  int error_cnt, total_checks, cyc, n;

  cad_datapath dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .op_valid, .op_code, .op_byte, .op_a, .op_b, .op_hi,
    .op_wide, .op_signed, .mul_form, .op_abort, .loop_active, .data_addr, .result,
    .result_valid, .quotient_reg, .remainder_reg, .div_done, .div_busy, .alu_status_reg,
    .cpu_control_reg, .user_int_disable, .program_window_hit, .program_window_addr);

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Master holds the request until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic op(input cad_op_t c, input logic bt, input logic [15:0] a, b);
    @(posedge pclk);
    op_valid <= 1'b1;
    op_code  <= c;
    op_byte  <= bt;
    op_a     <= a;
    op_b     <= b;
    @(posedge pclk);
    op_valid <= 1'b0;
    #1;
  endtask : op

  // Flags compared as {half carry, negative, overflow, zero, carry}
  task automatic alu(input cad_op_t c, input logic bt, input logic [15:0] a, b, r,
                     input logic [4:0] f);
    op(c, bt, a, b);
    chk("alu result", result, {16'h0, r});
    chk("flags", {alu_status_reg[8], alu_status_reg[3:0]}, f);
  endtask : alu

  task automatic res(input cad_op_t c, input logic [15:0] a, b, input logic [31:0] e);
    op(c, 1'b0, a, b);
    chk("valid", result_valid, 1'b1);
    chk("result", c == CAD_OP_MUL ? result : {16'h0, result[15:0]}, e);
  endtask : res

  task automatic dv(input logic w, s, input logic [15:0] hi, a, b, q, r);
    op_wide   = w;
    op_signed = s;
    op_hi     = hi;
    op(CAD_OP_DIV, 1'b0, a, b);
    n = 1;
    while (div_done !== 1'b1 && n < 40) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk("div cycles", n, 19);
    chk("quotient", quotient_reg, q);
    chk("remainder", remainder_reg, r);
  endtask : dv

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 8000) begin
      error_cnt++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {presetn, psel, penable, pwrite, op_valid, op_byte, op_wide, op_signed} = '0;
    {op_abort, loop_active, paddr, pwdata, op_a, op_b, op_hi, data_addr} = '0;
    pstrb = 4'hf;
    op_code = CAD_OP_NOP;
    mul_form = CAD_MUL_SS;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, CAD_STATUS_OFS, 0);
    chk("status reset", rd, 0);
    apb(0, CAD_CONTROL_OFS, 0);
    chk("control reset", rd, 0);
    apb(0, 8'h10, 0);
    chk("unmapped err", err, 1'b1);
    chk("unmapped data", rd, 0);
    apb(1, CAD_CONTROL_OFS, 32'hc);
    apb(0, CAD_CONTROL_OFS, 0);
    chk("control set", rd, 32'h4);
    chk("control port", cpu_control_reg, 16'h0004);
    apb(1, CAD_PAGE_OFS, 32'h5a);
    apb(0, CAD_PAGE_OFS, 0);
    chk("page", rd, 32'h5a);
    data_addr = 16'h8123;
    repeat (2) @(posedge pclk);
    #1;
    chk("window hit", program_window_hit, 1'b1);
    chk("window addr", program_window_addr, {8'h5a, 15'h0123});
    apb(1, CAD_CONTROL_OFS, 0);
    repeat (2) @(posedge pclk);
    #1;
    chk("window off", program_window_hit, 1'b0);
    apb(1, CAD_STATUS_OFS, 32'he0);
    apb(0, CAD_STATUS_OFS, 0);
    chk("level seven", rd, 32'he0);
    chk("int disable", user_int_disable, 1'b1);
    apb(1, CAD_INTCTL_OFS, 32'h8000);
    apb(1, CAD_STATUS_OFS, 32'h20);
    apb(0, CAD_STATUS_OFS, 0);
    chk("level locked", rd, 32'he0);
    apb(1, CAD_INTCTL_OFS, 0);
    apb(1, CAD_STATUS_OFS, 32'h2);
    apb(0, CAD_STATUS_OFS, 0);
    chk("level open", rd, 32'h2);
    chk("int enable", user_int_disable, 1'b0);
    alu(CAD_OP_ADD, 0, 16'h0000, 16'h0000, 16'h0000, 5'b00010);
    alu(CAD_OP_ADD, 0, 16'hffff, 16'h0001, 16'h0000, 5'b10011);
    alu(CAD_OP_ADD, 0, 16'h7fff, 16'h0001, 16'h8000, 5'b11100);
    alu(CAD_OP_ADD, 1, 16'h000f, 16'h0001, 16'h0010, 5'b10000);
    alu(CAD_OP_ADD, 1, 16'h0080, 16'h0080, 16'h0000, 5'b00101);
    alu(CAD_OP_SUB, 0, 16'h0005, 16'h0003, 16'h0002, 5'b10001);
    alu(CAD_OP_SUB, 0, 16'h0003, 16'h0005, 16'hfffe, 5'b01000);
    res(CAD_OP_ADC, 16'h0001, 16'h0001, 32'h2);
    res(CAD_OP_SBB, 16'h0005, 16'h0003, 32'h1);
    res(CAD_OP_AND, 16'hf0f0, 16'hff00, 32'hf000);
    res(CAD_OP_OR, 16'hf0f0, 16'hff00, 32'hfff0);
    res(CAD_OP_XOR, 16'hf0f0, 16'hff00, 32'h0ff0);
    res(CAD_OP_ASR, 16'h8000, 16'h000f, 32'hffff);
    res(CAD_OP_SHL, 16'h0001, 16'h000f, 32'h8000);
    res(CAD_OP_LSR, 16'h8000, 16'h000f, 32'h0001);
    mul_form = CAD_MUL_SS;
    res(CAD_OP_MUL, 16'hffff, 16'h0002, 32'hfffffffe);
    mul_form = CAD_MUL_UU;
    res(CAD_OP_MUL, 16'hffff, 16'hffff, 32'hfffe0001);
    mul_form = CAD_MUL_SL;
    res(CAD_OP_MUL, 16'hfffe, 16'h001f, 32'hffffffc2);
    mul_form = CAD_MUL_UL;
    res(CAD_OP_MUL, 16'hffff, 16'h001f, 32'h001effe1);
    mul_form = CAD_MUL_US;
    res(CAD_OP_MUL, 16'hffff, 16'hffff, 32'hffff0001);
    mul_form = CAD_MUL_U8;
    res(CAD_OP_MUL, 16'h12ff, 16'h34ff, 32'h0000fe01);
    dv(1, 0, 16'h0001, 16'h0000, 16'h0003, 16'h5555, 16'h0001);
    dv(0, 1, 16'h0000, 16'hfff9, 16'h0002, 16'hfffd, 16'hffff);
    dv(1, 1, 16'hffff, 16'hfff9, 16'h0002, 16'hfffd, 16'hffff);
    dv(0, 0, 16'h0000, 16'd100, 16'd7, 16'd14, 16'd2);
    op(CAD_OP_DIV, 0, 16'd100, 16'd7);
    op(CAD_OP_ADD, 0, 16'h0001, 16'h0001);
    chk("refused", result_valid, 1'b0);
    op_abort <= 1'b1;
    @(posedge pclk);
    op_abort <= 1'b0;
    n = 0;
    repeat (25) begin
      @(posedge pclk);
      n += div_done;
    end
    chk("abort done", n, 0);
    chk("abort busy", div_busy, 1'b0);
    loop_active <= 1'b1;
    repeat (2) @(posedge pclk);
    #1;
    chk("loop on", alu_status_reg[CAD_RA_BIT], 1'b1);
    loop_active <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    chk("loop off", alu_status_reg[CAD_RA_BIT], 1'b0);
    results();
  end
endmodule : test_cad_datapath

`default_nettype wire
